// *** common/suspend_ctrl_defs.vh ***
`ifndef SUSPEND_CTRL_DEFS_VH
`define SUSPEND_CTRL_DEFS_VH
`define OPC_SUSPEND      8'hb0
`define OPC_RESUME       8'hd0
`define OPC_READ3        8'h03
`define OPC_READ4_A      8'h0b
`define OPC_READ4_B      8'h0c
`define OPC_READ4_C      8'h13
`define OPC_BUF_READ     8'hd4
`define OPC_ERASE_4K     8'h20
`define OPC_ERASE_32K    8'h52
`define OPC_ERASE_64K    8'hd8
`define OPC_CHIP_A       8'hc7
`define OPC_CHIP_B       8'h60
`define OPC_PROGRAM      8'h02
`define OPC_BUF_WRITE    8'h84
`define OPC_BUF_TO_MAIN  8'h88
`define OPC_WRSR_A       8'h01
`define OPC_WRSR_B       8'h31
`define OPC_WRSC         8'h71
`define UNDEF_BYTE       8'hff
`define SECTOR_HI        22
`define SECTOR_LO        18
`define CLK_MHZ          20
`define SUSPEND_LATENCY_NS  20000
`define SUSPEND_LATENCY_CYC ((`SUSPEND_LATENCY_NS * `CLK_MHZ) / 1000)
`endif

// *** src/program_erase_suspend_control.v ***
`timescale 1ns/1ps
`include "suspend_ctrl_defs.vh"

// Functional notes
// - Suspend is opcode b0 alone, trailing bytes ignored
// - Chip select release pauses running operation
// - Set program or erase suspended flag
// - Busy indicator clears once suspended
// - Suspend only on whole opcode, byte boundary
// - Suspend ignores write enable latch
// - Chip erase cannot be suspended
// - Reads of suspended sector give undefined data
// - Streaming read undefined inside suspended sector
// - Program to erase-suspended sector aborts, clears latch
// - Program during erase suspend may suspend too
// - No new erase while erase suspended
// - Program suspend aborts program and erase
// - Other disallowed commands ignored, latch untouched
// - No suspend with auto powerdown enabled
// - Same bank allowed, different sector only
// - Busy reads only on read-while-write, no buffer
// - Suspended: array and buffer reads accepted
// - Erases refused while busy or suspended
// - Programs accepted when idle or during erase suspend
// - Suspend/resume acceptance per state table
// - Busy reads only in the other bank
// - Suspend reads/programs only other sectors
module program_erase_suspend_control
(
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Serial pins
  input  wire        cs_n,
  input  wire        sck,
  input  wire        si,
  output wire        so,
  output wire        so_oe_n,
  // Configuration
  input  wire        auto_deep_powerdown_enable,
  input  wire        auto_ultra_deep_powerdown_enable,
  input  wire        rww_variant,
  input  wire [4:0]  rww_boundary_sector,
  // Program/erase core status
  input  wire        core_busy,
  input  wire        core_is_program,
  input  wire        core_is_chip,
  input  wire [4:0]  core_sector,
  // Command forwarding
  output reg         cmd_start_q,
  output reg  [7:0]  cmd_opcode_q,
  output reg  [31:0] cmd_addr_q,
  output reg         data_strobe_q,
  output reg  [7:0]  data_byte_q,
  // Array read port
  output reg         read_req_q,
  output reg  [31:0] read_addr_q,
  input  wire [7:0]  array_rdata,
  output reg         read_undefined_q,
  // Suspend control and status
  output reg         hold_program_q,
  output reg         hold_erase_q,
  output reg         resume_q,
  output reg         wel_clear_q,
  output reg         program_suspended_flag_q,
  output reg         erase_suspended_flag_q,
  output wire        ready_busy_indicator
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_OPC  = 4'b0010;
  localparam ST_ADDR = 4'b0100;
  localparam ST_DATA = 4'b1000;
  localparam SS_IDLE = 2'b01;
  localparam SS_WAIT = 2'b10;
  localparam integer SUS_CYC_FULL = `SUSPEND_LATENCY_CYC;
  localparam [15:0]  SUS_CYC      = SUS_CYC_FULL[15:0];

  function [2:0] addr_bytes;
    input [7:0] opc;
    begin
      case (opc)
        `OPC_READ4_A, `OPC_READ4_B, `OPC_READ4_C,
        `OPC_ERASE_4K, `OPC_ERASE_32K, `OPC_ERASE_64K: addr_bytes = 3'd4;
        `OPC_READ3, `OPC_BUF_READ, `OPC_PROGRAM,
        `OPC_BUF_WRITE, `OPC_BUF_TO_MAIN: addr_bytes = 3'd3;
        default: addr_bytes = 3'd0;
      endcase
    end
  endfunction

  function is_array_read;
    input [7:0] opc;
    begin
      is_array_read = (opc == `OPC_READ3) || (opc == `OPC_READ4_A) ||
                      (opc == `OPC_READ4_B) || (opc == `OPC_READ4_C);
    end
  endfunction

  function [4:0] sector_of;
    input [31:0] a;
    begin
      sector_of = a[`SECTOR_HI:`SECTOR_LO];
    end
  endfunction

  // Pin synchronisers: bit 0 cs_n, bit 1 sck, bit 2 si
  reg  [2:0]  sync1_q;
  reg  [2:0]  sync2_q;
  reg         sck_prev_q;
  reg         cs_prev_q;
  reg  [3:0]  state_q;
  reg  [2:0]  bit_cnt_q;
  reg  [6:0]  shift_q;
  reg  [7:0]  opcode_q;
  reg  [31:0] addr_q;
  reg  [2:0]  addr_left_q;
  reg         read_ok_q;
  reg         load_q;
  reg  [7:0]  out_shift_q;
  reg         so_q;
  reg         so_oe_n_q;
  reg  [1:0]  sus_state_q;
  reg  [15:0] sus_cnt_q;
  reg         sus_prog_q;
  reg  [4:0]  ps_sector_q;
  reg  [4:0]  es_sector_q;

  wire        cs_n_s   = sync2_q[0];
  wire        sck_s    = sync2_q[1];
  wire        si_s     = sync2_q[2];
  wire        sck_rise = sck_s & ~sck_prev_q;
  wire        sck_fall = ~sck_s & sck_prev_q;
  wire        cs_rise  = cs_n_s & ~cs_prev_q;
  wire        cs_fall  = ~cs_n_s & cs_prev_q;
  wire        byte_end = sck_rise & (bit_cnt_q == 3'd7) & ~cs_n_s;
  wire [7:0]  rx_byte  = {shift_q, si_s};
  wire [31:0] addr_nx  = {addr_q[23:0], rx_byte};
  wire [31:0] addr_inc = addr_q + 32'h1;
  // Operation counts as running until its own suspend flag is set
  wire running = core_busy &
                 ~(core_is_program ? program_suspended_flag_q
                                   : erase_suspended_flag_q);
  wire any_sus = program_suspended_flag_q | erase_suspended_flag_q;
  wire complete = cs_rise & (bit_cnt_q == 3'd0) & (state_q == ST_DATA);
  wire is_erase = (opcode_q == `OPC_ERASE_4K) ||
                  (opcode_q == `OPC_ERASE_32K) ||
                  (opcode_q == `OPC_ERASE_64K) ||
                  (opcode_q == `OPC_CHIP_A) || (opcode_q == `OPC_CHIP_B);
  wire is_prog  = (opcode_q == `OPC_PROGRAM) ||
                  (opcode_q == `OPC_BUF_WRITE) ||
                  (opcode_q == `OPC_BUF_TO_MAIN);
  wire is_wrsr  = (opcode_q == `OPC_WRSR_A) ||
                  (opcode_q == `OPC_WRSR_B) || (opcode_q == `OPC_WRSC);
  wire prog_hits_es = erase_suspended_flag_q &
                      (opcode_q != `OPC_BUF_WRITE) &
                      (sector_of(addr_q) == es_sector_q);
  wire can_suspend = running & ~core_is_chip &
                     ~auto_deep_powerdown_enable &
                     ~auto_ultra_deep_powerdown_enable &
                     ~program_suspended_flag_q &
                     (core_is_program | ~erase_suspended_flag_q) &
                     (sus_state_q == SS_IDLE);
  // Read grant taken at the end of the address
  wire [4:0] rd_sec = sector_of(addr_nx);
  wire rd_grant = running ? (rww_variant & is_array_read(opcode_q) &
                             ((rd_sec >= rww_boundary_sector) !=
                              (core_sector >= rww_boundary_sector)))
                          : 1'b1;

  function sus_hit;
    input [31:0] a;
    begin
      sus_hit = (program_suspended_flag_q &
                 (sector_of(a) == ps_sector_q)) |
                (erase_suspended_flag_q & (sector_of(a) == es_sector_q));
    end
  endfunction

  assign so                   = so_q;
  assign so_oe_n              = so_oe_n_q;
  assign ready_busy_indicator = running;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q    <= 3'h1;
      sync2_q    <= 3'h1;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end
    else
    begin
      sync1_q    <= {si, sck, cs_n};
      sync2_q    <= sync1_q;
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
    end
  end

  // Serial command receiver
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q       <= ST_IDLE;
      bit_cnt_q     <= 3'h0;
      shift_q       <= 7'h00;
      opcode_q      <= 8'h00;
      addr_q        <= 32'h0;
      addr_left_q   <= 3'h0;
      read_ok_q     <= 1'b0;
      read_req_q    <= 1'b0;
      read_addr_q   <= 32'h0;
      data_strobe_q <= 1'b0;
      data_byte_q   <= 8'h00;
    end
    else
    begin
      read_req_q    <= 1'b0;
      data_strobe_q <= 1'b0;
      if (cs_n_s)
      begin
        state_q   <= ST_IDLE;
        bit_cnt_q <= 3'h0;
        read_ok_q <= 1'b0;
      end
      else
      begin
        if (cs_fall)
          state_q <= ST_OPC;
        if (sck_rise)
        begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          shift_q   <= rx_byte[6:0];
        end
        if (byte_end)
        begin
          case (state_q)
            ST_OPC:
            begin
              opcode_q    <= rx_byte;
              addr_q      <= 32'h0;
              addr_left_q <= addr_bytes(rx_byte);
              state_q     <= (addr_bytes(rx_byte) == 3'd0) ? ST_DATA
                                                           : ST_ADDR;
            end
            ST_ADDR:
            begin
              addr_q      <= addr_nx;
              addr_left_q <= addr_left_q - 3'h1;
              if (addr_left_q == 3'd1)
              begin
                state_q <= ST_DATA;
                if (is_array_read(opcode_q) ||
                    (opcode_q == `OPC_BUF_READ))
                begin
                  read_ok_q   <= rd_grant;
                  read_req_q  <= rd_grant;
                  read_addr_q <= addr_nx;
                end
              end
            end
            ST_DATA:
            begin
              // Bytes after a suspend opcode go nowhere
              if (read_ok_q)
              begin
                addr_q      <= addr_inc;
                read_req_q  <= 1'b1;
                read_addr_q <= addr_inc;
              end
              else if (opcode_q != `OPC_SUSPEND)
              begin
                data_strobe_q <= 1'b1;
                data_byte_q   <= rx_byte;
              end
            end
            default: state_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Read data out, undefined inside suspended sectors
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      load_q           <= 1'b0;
      out_shift_q      <= 8'h00;
      so_q             <= 1'b0;
      so_oe_n_q        <= 1'b1;
      read_undefined_q <= 1'b0;
    end
    else
    begin
      load_q <= read_req_q;
      if (read_req_q)
        read_undefined_q <= is_array_read(opcode_q) &
                            sus_hit(read_addr_q);
      if (load_q)
        out_shift_q <= read_undefined_q ? `UNDEF_BYTE
                                        : array_rdata;
      else if (sck_fall & read_ok_q)
      begin
        so_q        <= out_shift_q[7];
        so_oe_n_q   <= 1'b0;
        out_shift_q <= {out_shift_q[6:0], 1'b0};
      end
      if (cs_n_s)
        so_oe_n_q <= 1'b1;
    end
  end

  // Command acceptance at chip select release
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmd_start_q              <= 1'b0;
      cmd_opcode_q             <= 8'h00;
      cmd_addr_q               <= 32'h0;
      wel_clear_q              <= 1'b0;
      resume_q                 <= 1'b0;
      hold_program_q           <= 1'b0;
      hold_erase_q             <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      erase_suspended_flag_q   <= 1'b0;
      ps_sector_q              <= 5'h00;
      es_sector_q              <= 5'h00;
      sus_state_q              <= SS_IDLE;
      sus_cnt_q                <= 16'h0;
      sus_prog_q               <= 1'b0;
    end
    else
    begin
      cmd_start_q <= 1'b0;
      wel_clear_q <= 1'b0;
      resume_q    <= 1'b0;
      case (sus_state_q)
        SS_IDLE: sus_cnt_q <= 16'h0;
        SS_WAIT:
        begin
          sus_cnt_q <= sus_cnt_q + 16'h1;
          if (sus_cnt_q >= SUS_CYC - 16'h1)
          begin
            sus_state_q <= SS_IDLE;
            if (sus_prog_q)
            begin
              program_suspended_flag_q <= 1'b1;
              ps_sector_q              <= core_sector;
            end
            else
            begin
              erase_suspended_flag_q <= 1'b1;
              es_sector_q            <= core_sector;
            end
          end
        end
        default: sus_state_q <= SS_IDLE;
      endcase
      // Partial bytes or incomplete commands do nothing
      if (complete)
      begin
        if (opcode_q == `OPC_SUSPEND)
        begin
          // Write enable latch never consulted here
          if (can_suspend)
          begin
            sus_state_q    <= SS_WAIT;
            sus_prog_q     <= core_is_program;
            hold_program_q <= hold_program_q | core_is_program;
            hold_erase_q   <= hold_erase_q | ~core_is_program;
          end
        end
        else if (opcode_q == `OPC_RESUME)
        begin
          if (any_sus & ~running & (sus_state_q == SS_IDLE))
          begin
            resume_q <= 1'b1;
            if (program_suspended_flag_q)
            begin
              program_suspended_flag_q <= 1'b0;
              hold_program_q           <= 1'b0;
            end
            else
            begin
              erase_suspended_flag_q <= 1'b0;
              hold_erase_q           <= 1'b0;
            end
          end
        end
        else if (is_erase)
        begin
          if (program_suspended_flag_q & ~running)
            wel_clear_q <= 1'b1;
          else if (~running & ~any_sus)
          begin
            cmd_start_q  <= 1'b1;
            cmd_opcode_q <= opcode_q;
            cmd_addr_q   <= addr_q;
          end
        end
        else if (is_prog)
        begin
          if (running)
            wel_clear_q <= 1'b0;
          else if (program_suspended_flag_q | prog_hits_es)
            wel_clear_q <= 1'b1;
          else
          begin
            cmd_start_q  <= 1'b1;
            cmd_opcode_q <= opcode_q;
            cmd_addr_q   <= addr_q;
          end
        end
        else if (is_wrsr)
        begin
          if (~running & ~any_sus)
          begin
            cmd_start_q  <= 1'b1;
            cmd_opcode_q <= opcode_q;
            cmd_addr_q   <= addr_q;
          end
        end
        else if (~(is_array_read(opcode_q) ||
                   (opcode_q == `OPC_BUF_READ)))
        begin
          // Remaining commands are the core's to police
          cmd_start_q  <= 1'b1;
          cmd_opcode_q <= opcode_q;
          cmd_addr_q   <= addr_q;
        end
      end
    end
  end

endmodule // program_erase_suspend_control

// *** testbench/program_erase_suspend_control_tb.sv ***
`timescale 1ns/1ps
`include "suspend_ctrl_defs.vh"
module program_erase_suspend_control_tb;
  reg         clk, sys_rst, pd_deep, pd_ultra, rww, busy, is_prog, is_chip;
  reg  [4:0]  sector;
  wire        cs_n, sck, si, so, so_oe_n, cmd_start_q, read_req_q;
  wire [7:0]  cmd_opcode_q;
  wire        read_undefined_q, hold_program_q, hold_erase_q, resume_q;
  wire        wel_clear_q, program_suspended_flag_q, erase_suspended_flag_q;
  wire        ready_busy_indicator;
  integer     n_start, n_wel, n_res, n_rd, uix, cycles, mismatches, checked, i;
  reg         req_d;
  reg  [7:0]  ulog;
  reg  [7:0]  pgm [0:2];
  integer     n_oe, n_ds;
  wire        data_strobe_q;
  wire [31:0] cmd_addr_q, read_addr_q;
  // Released so line floats to its pull-up
  wire        so_line = so_oe_n ? 1'b1 : so;
  spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
    .so(so_line));
  program_erase_suspend_control uut
  (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_oe_n(so_oe_n), .auto_deep_powerdown_enable(pd_deep),
    .auto_ultra_deep_powerdown_enable(pd_ultra), .rww_variant(rww),
    .rww_boundary_sector(5'h10), .core_busy(busy), .core_is_program(is_prog),
    .core_is_chip(is_chip), .core_sector(sector), .cmd_start_q(cmd_start_q),
    .cmd_opcode_q(cmd_opcode_q), .cmd_addr_q(cmd_addr_q),
    .data_strobe_q(data_strobe_q), .data_byte_q(), .read_req_q(read_req_q),
    .read_addr_q(read_addr_q),
    .array_rdata(8'h5a), .read_undefined_q(read_undefined_q),
    .hold_program_q(hold_program_q), .hold_erase_q(hold_erase_q),
    .resume_q(resume_q), .wel_clear_q(wel_clear_q),
    .program_suspended_flag_q(program_suspended_flag_q),
    .erase_suspended_flag_q(erase_suspended_flag_q),
    .ready_busy_indicator(ready_busy_indicator)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulse counters; strobes pulse one cycle, n_oe counts cycles with so enabled
  always @(posedge clk)
  begin
    req_d <= read_req_q;
    n_start <= n_start + cmd_start_q;
    n_wel <= n_wel + wel_clear_q;
    n_res <= n_res + resume_q;
    n_rd <= n_rd + read_req_q;
    n_oe <= n_oe + !so_oe_n;
    n_ds <= n_ds + data_strobe_q;
    if (req_d)
    begin
      ulog[uix[2:0]] <= read_undefined_q;
      uix <= uix + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  task check(input string what, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task cmd(input [55:0] d, input integer n);
    begin
      n_start = 0;
      n_wel = 0;
      n_res = 0;
      n_rd = 0;
      n_oe = 0;
      n_ds = 0;
      uix = 0;
      ulog = 8'hxx;
      host.frame(d, n);
      #1;
    end
  endtask
  task stop_test;
    begin
      $display("Checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    {sys_rst, pd_deep, pd_ultra, rww, busy, is_prog, is_chip} = 7'h40;
    sector = 5'h03;
    {n_start, n_wel, n_res, n_rd, uix, cycles, mismatches, checked} = 0;
    {n_oe, n_ds} = 0;
    {req_d, ulog} = 9'h000;
    pgm[0] = `OPC_PROGRAM;
    pgm[1] = `OPC_BUF_WRITE;
    pgm[2] = `OPC_BUF_TO_MAIN;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    cmd({`OPC_SUSPEND, 48'h0}, 8);
    check("idle hold", 0, hold_erase_q);
    check("idle flag", 0, erase_suspended_flag_q);
    $display("Test idle suspend done");
    busy <= 1'b1;
    is_chip <= 1'b1;
    cmd({`OPC_SUSPEND, 48'h0}, 8);
    check("chip hold", 0, hold_erase_q);
    is_chip <= 1'b0;
    pd_deep <= 1'b1;
    cmd({`OPC_SUSPEND, 48'h0}, 8);
    check("deep hold", 0, hold_erase_q);
    pd_deep <= 1'b0;
    pd_ultra <= 1'b1;
    cmd({`OPC_SUSPEND, 48'h0}, 8);
    check("ultra hold", 0, hold_erase_q);
    pd_ultra <= 1'b0;
    cmd({`OPC_SUSPEND, 48'h0}, 5);
    check("part hold", 0, hold_erase_q);
    $display("Test refused suspend done");
    cmd({`OPC_READ3, 24'h100000, 24'h0}, 40);
    check("busy read", 0, n_rd);
    check("busy read oe", 0, n_oe);
    rww <= 1'b1;
    cmd({`OPC_READ3, 24'h500000, 24'h0}, 40);
    check("rww read", 1, n_rd != 0);
    check("rww data", 8'h5a, host.rx_q);
    check("rww addr", 32'h500001, read_addr_q);
    cmd({`OPC_READ3, 24'h100000, 24'h0}, 40);
    check("bank read", 0, n_rd);
    cmd({`OPC_BUF_READ, 24'h000000, 24'h0}, 40);
    check("rww buf", 0, n_rd);
    rww <= 1'b0;
    $display("Test busy reads done");
    cmd({`OPC_SUSPEND, 8'ha5, 40'h0}, 16);
    check("erase hold", 1, hold_erase_q);
    check("trailing byte", 0, n_ds);
    repeat (400) @(posedge clk);
    #1;
    check("erase flag", 1, erase_suspended_flag_q);
    check("prog flag", 0, program_suspended_flag_q);
    check("ready", 0, ready_busy_indicator);
    $display("Test erase suspend done");
    cmd({`OPC_READ3, 24'h0bffff, 24'h0}, 48);
    check("undef in", 8'h2, ulog[1:0]);
    check("undef in data", 8'hff, host.rx_q);
    cmd({`OPC_READ3, 24'h0fffff, 24'h0}, 48);
    check("undef out", 8'h1, ulog[1:0]);
    check("undef out data", 8'h5a, host.rx_q);
    cmd({`OPC_READ4_A, 32'h000c0000, 16'h0}, 48);
    check("read4 undef", 1, ulog[0]);
    check("read4 data", 8'hff, host.rx_q);
    cmd({`OPC_BUF_READ, 24'h000000, 24'h0}, 40);
    check("susp buf", 1, n_rd != 0);
    check("susp buf data", 8'h5a, host.rx_q);
    $display("Test suspended reads done");
    cmd({`OPC_PROGRAM, 24'h0c0010, 24'h55}, 40);
    check("same wel", 1, n_wel);
    check("same start", 0, n_start);
    for (i = 0; i < 3; i = i + 1)
    begin
      cmd({pgm[i], 24'h140010, 24'h55}, 40);
      check("prog start", 1, n_start);
      check("prog opcode", pgm[i], cmd_opcode_q);
      check("prog addr", 32'h140010, cmd_addr_q);
      check("prog data", 1, n_ds);
    end
    cmd({`OPC_ERASE_4K, 32'h00140000, 16'h0}, 40);
    check("erase start", 0, n_start);
    cmd({`OPC_WRSR_A, 8'h00, 40'h0}, 16);
    check("wrsr start", 0, n_start);
    check("wrsr wel", 0, n_wel);
    $display("Test erase suspend commands done");
    is_prog <= 1'b1;
    sector <= 5'h05;
    cmd({`OPC_SUSPEND, 48'h0}, 8);
    check("prog hold", 1, hold_program_q);
    repeat (400) @(posedge clk);
    #1;
    check("both flags", 3, {program_suspended_flag_q,
      erase_suspended_flag_q});
    cmd({`OPC_PROGRAM, 24'h180000, 24'h55}, 40);
    check("ps wel", 1, n_wel);
    check("ps start", 0, n_start);
    cmd({`OPC_ERASE_64K, 32'h00180000, 16'h0}, 40);
    check("ps erase", 0, n_start);
    $display("Test program suspend done");
    cmd({`OPC_RESUME, 48'h0}, 8);
    check("resume", 1, n_res);
    check("after resume", 1, {program_suspended_flag_q,
      erase_suspended_flag_q});
    is_prog <= 1'b0;
    sector <= 5'h03;
    cmd({`OPC_RESUME, 48'h0}, 8);
    check("second resume", 0, erase_suspended_flag_q);
    $display("Test resume done");
    stop_test;
  end
endmodule // program_erase_suspend_control_tb

// *** testbench/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model
(
  // Clock
  input  wire clk,
  // Serial pins
  output reg  cs_n,
  output reg  sck,
  output reg  si,
  input  wire so
);
  reg [7:0] rx_q;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rx_q = 8'h00;
  end
  // Mode 0, 400 ns bit time; sck idles low between frames
  task frame(input [55:0] d, input integer n);
    integer i;
    begin
      @(posedge clk) cs_n <= 1'b0;
      for (i = 0; i < n; i = i + 1)
      begin
        si <= d[55 - i];
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        rx_q <= {rx_q[6:0], so};
        repeat (4) @(posedge clk);
        sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (12) @(posedge clk);
    end
  endtask
endmodule // spi_host_model

// *** testbench/suspend_ctrl_asserts.sv ***
`timescale 1ns/1ps
module suspend_ctrl_checker
(
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Pins, configuration and core status
  input wire cs_n,
  input wire auto_deep_powerdown_enable,
  input wire auto_ultra_deep_powerdown_enable,
  input wire rww_variant,
  input wire core_busy,
  input wire core_is_program,
  input wire core_is_chip,
  // Outputs watched
  input wire read_req_q,
  input wire cmd_start_q,
  input wire wel_clear_q,
  input wire resume_q,
  input wire hold_program_q,
  input wire hold_erase_q,
  input wire program_suspended_flag_q,
  input wire erase_suspended_flag_q,
  input wire ready_busy_indicator
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence hold_s;
    $rose(hold_erase_q) || $rose(hold_program_q);
  endsequence
  sequence erase_paused_s;
    ##[395:405] $rose(erase_suspended_flag_q);
  endsequence
  sequence prog_paused_s;
    ##[395:405] $rose(program_suspended_flag_q);
  endsequence
  erase_latency_a:
    assert property ($rose(hold_erase_q) |-> erase_paused_s)
    else $error("erase flag not set in time");
  prog_latency_a:
    assert property ($rose(hold_program_q) |-> prog_paused_s)
    else $error("program flag not set in time");
  ready_shown_a:
    assert property ((erase_suspended_flag_q && core_busy && !core_is_program)
      |-> !ready_busy_indicator) else $error("busy after suspend");
  busy_shown_a:
    assert property ((core_busy && !erase_suspended_flag_q &&
      !program_suspended_flag_q) |-> ready_busy_indicator)
    else $error("ready while running");
  erase_cause_a:
    assert property ($rose(hold_erase_q) |-> $past(core_busy && !core_is_chip))
    else $error("erase hold without block erase");
  powerdown_a:
    assert property (hold_s |-> $past(!auto_deep_powerdown_enable &&
      !auto_ultra_deep_powerdown_enable)) else $error("hold with powerdown");
  cs_release_a:
    assert property (hold_s |-> cs_n) else $error("hold before release");
  abort_only_a:
    assert property (wel_clear_q |-> !cmd_start_q) else $error("abort started");
  busy_read_a:
    assert property ((read_req_q && !rww_variant) |-> (!core_busy ||
      program_suspended_flag_q || erase_suspended_flag_q))
    else $error("array read while running");
  resume_ok_a:
    assert property (resume_q |-> $past(program_suspended_flag_q ||
      erase_suspended_flag_q)) else $error("resume without suspend");
endmodule // suspend_ctrl_checker

bind program_erase_suspend_control suspend_ctrl_checker chk
(
  .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .auto_deep_powerdown_enable(auto_deep_powerdown_enable),
  .auto_ultra_deep_powerdown_enable(auto_ultra_deep_powerdown_enable),
  .rww_variant(rww_variant), .core_busy(core_busy),
  .core_is_program(core_is_program), .core_is_chip(core_is_chip),
  .read_req_q(read_req_q), .cmd_start_q(cmd_start_q),
  .wel_clear_q(wel_clear_q), .resume_q(resume_q),
  .hold_program_q(hold_program_q), .hold_erase_q(hold_erase_q),
  .program_suspended_flag_q(program_suspended_flag_q),
  .erase_suspended_flag_q(erase_suspended_flag_q),
  .ready_busy_indicator(ready_busy_indicator)
);
